// ---- src/pit_pkg.sv ----
//----------------------------------------------------------------------
// Purpose: Shared constants and types for the interval timer bus block
// Assumes: Single clock domain, all pins sampled on sys_clk
// Notes:   Control word field positions and encodings live here
//----------------------------------------------------------------------
package pit_pkg;

  //--------------------------------------------------------------------
  // Sizes
  //--------------------------------------------------------------------
  localparam int NUM_COUNTERS = 3;

  //--------------------------------------------------------------------
  // Port select decode
  //--------------------------------------------------------------------
  localparam logic [1:0] PS_CONTROL = 2'h3;

  //--------------------------------------------------------------------
  // Control word fields
  //--------------------------------------------------------------------
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_RW_HI = 5;
  localparam int CW_RW_LO = 4;
  localparam int CW_CFG_HI = 5;
  localparam int CW_RB_COUNT_N = 5;
  localparam int CW_RB_STATUS_N = 4;
  localparam int CW_RB_SEL_BASE = 1;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LOW = 2'h1;
  localparam logic [1:0] RW_HIGH = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;

  //--------------------------------------------------------------------
  // Reset values
  //--------------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [5:0] CFG_ZERO = 6'h00;

  //--------------------------------------------------------------------
  // Types
  //--------------------------------------------------------------------
  typedef enum logic {BYTE_LSB, BYTE_MSB} pit_byte_t;

  typedef struct packed {
    logic wr_pulse;
    logic rd_done;
    logic [1:0] port;
    logic [7:0] data;
  } pit_bus_req_t;

  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode;
    logic bcd;
  } pit_cfg_t;

endpackage

// ---- src/pit_strobe_sync.sv ----
//----------------------------------------------------------------------
// Purpose: Turns bus strobes into one-cycle write and read-end pulses
// Assumes: Pins are synchronous to sys_clk
// Notes:   A cycle is taken when its strobe is released
//----------------------------------------------------------------------
`timescale 1ns/1ns
module pit_strobe_sync
  import pit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] port_select,
  input wire logic [7:0] data_in,
  output pit_pkg::pit_bus_req_t req
);
  import pit_pkg::*;

  typedef struct packed {
    logic wr_low;
    logic rd_low;
    pit_bus_req_t req;
  } pit_strobe_state_t;

  pit_strobe_state_t st;
  pit_strobe_state_t next_st;
  logic wr_now;
  logic rd_now;

  // Strobes count only while chip select is low
  assign wr_now = !wr_n && !cs_n; // RQ1
  assign rd_now = !rd_n && !cs_n; // RQ1

  // Capture port while a cycle is open and data while a write is open, pulse at its end
  always_comb
  begin
    next_st = st;
    next_st.wr_low = wr_now;
    next_st.rd_low = rd_now;
    next_st.req.wr_pulse = st.wr_low && !wr_now; // RQ2
    next_st.req.rd_done = st.rd_low && !rd_now;
    if (wr_now || rd_now)
    begin
      next_st.req.port = port_select;
    end
    if (wr_now)
    begin
      next_st.req.data = data_in;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign req = st.req;
endmodule

// ---- src/pit_count_element.sv ----
//----------------------------------------------------------------------
// Purpose: 16-bit presettable down counter for one timer channel
// Assumes: count_clk and gate are synchronous inputs
// Notes:   Mode waveforms are reduced to output high at terminal count
//----------------------------------------------------------------------
`timescale 1ns/1ns
module pit_count_element
  import pit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic count_clk,
  input wire logic gate,
  input wire logic load_req,
  input wire logic [15:0] preload,
  input wire logic cfg_write,
  output logic [15:0] count,
  output logic load_ack,
  output logic out_level
);
  import pit_pkg::*;

  typedef struct packed {
    logic clk_q;
    logic armed;
    logic ack;
    logic out;
    logic [15:0] count;
  } pit_ce_state_t;

  pit_ce_state_t st;
  pit_ce_state_t next_st;
  logic rise;

  assign rise = count_clk && !st.clk_q;

  // Whole 16-bit preload enters at once on a count clock edge
  always_comb
  begin
    next_st = st;
    next_st.clk_q = count_clk;
    next_st.ack = 1'b0;
    if (cfg_write)
    begin
      next_st.armed = 1'b0;
      next_st.out = 1'b0;
    end
    else if (rise && load_req)
    begin
      next_st.count = preload; // RQ14
      next_st.ack = 1'b1;
      next_st.armed = 1'b1;
      next_st.out = 1'b0;
    end
    else if (rise && gate && st.armed)
    begin
      next_st.count = st.count - COUNT_ONE; // RQ9
      if (st.count == COUNT_ONE)
      begin
        next_st.out = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign load_ack = st.ack;
  assign out_level = st.out;
endmodule

// ---- src/pit_bus_interface.sv ----
//----------------------------------------------------------------------
// Purpose: Bus read/write logic and per-counter storage of a
//          three-channel interval timer
// Assumes: Host pins synchronous to sys_clk; data bus split in three
// Notes:   Control port cannot be read; status comes via read-back
//----------------------------------------------------------------------
// Operation
// RQ1: Strobes ignored unless chip select low
// RQ2: Host holds write strobe low whole cycle
// RQ3: Selected read strobe reads addressed counter
// RQ4: Selected write strobe writes control or count
// RQ5: Port three is the control register
// RQ6: Control register write-only; status via read-back
// RQ7: Three identical independent counters
// RQ8: Status holds control, output, null flag
// RQ9: Counting element is 16-bit down counter
// RQ10: Snapshot tracks count, freezes until read
// RQ11: One snapshot byte at a time
// RQ12: Reads return snapshot, never the counter
// RQ13: Count writes go bytewise into preload
// RQ14: Both preload bytes transfer together
// RQ15: Single-byte format zeroes the other byte
// RQ16: Data buffer drives only during reads
// RQ17: Ports 0..2 address counters 0..2
// RQ18: Control bits 7:6 select counter
// RQ19: Control bits 5:4 select byte access
// RQ20: Host writes control word before count
// RQ21: Reading control port changes nothing
//----------------------------------------------------------------------
`timescale 1ns/1ns
module pit_bus_interface
  import pit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] port_select,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [pit_pkg::NUM_COUNTERS-1:0] count_clk,
  input wire logic [pit_pkg::NUM_COUNTERS-1:0] gate,
  output logic [pit_pkg::NUM_COUNTERS-1:0] counter_out
);
  import pit_pkg::*;

  //--------------------------------------------------------------------
  // Top-level state
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data_out;
    logic oe_n;
  } pit_top_state_t;

  typedef struct packed {
    pit_cfg_t cfg;
    logic [7:0] preload_low;
    logic [7:0] preload_high;
    logic [7:0] snapshot_latch_low;
    logic [7:0] snapshot_latch_high;
    logic frozen;
    logic status_held;
    logic [7:0] status;
    pit_byte_t wr_phase;
    pit_byte_t rd_phase;
    logic load_pending;
    logic null_count;
  } pit_chan_t;

  pit_top_state_t st;
  pit_top_state_t next_st;
  pit_bus_req_t req;
  logic cw_write;
  logic [1:0] cw_sel;
  logic [1:0] cw_rw;
  logic rd_drive;
  logic [7:0] rd_byte [NUM_COUNTERS];

  //--------------------------------------------------------------------
  // Read/write strobe capture
  //--------------------------------------------------------------------
  pit_strobe_sync u_strobe (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .port_select(port_select),
    .data_in(data_in),
    .req(req)
  );

  // Control word decode on a write to the control port
  assign cw_write = req.wr_pulse && (req.port == PS_CONTROL); // RQ4 RQ5
  assign cw_sel = req.data[CW_SEL_HI:CW_SEL_LO]; // RQ18
  assign cw_rw = req.data[CW_RW_HI:CW_RW_LO]; // RQ19

  // Buffer drives only on a selected read of a counter port
  assign rd_drive = !cs_n && !rd_n && (port_select != PS_CONTROL); // RQ16 RQ6 RQ21

  //--------------------------------------------------------------------
  // Counter channels
  //--------------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_COUNTERS; ch++)
  begin : g_chan
    pit_chan_t cst;
    pit_chan_t next_cst;
    logic my_cw;
    logic my_latch;
    logic rb_hit;
    logic rb_count;
    logic rb_status;
    logic my_wr;
    logic my_rd;
    logic [15:0] ce_count;
    logic ce_ack;
    logic ce_out;

    // Per-channel decode of the captured bus cycle
    assign my_cw = cw_write && (cw_sel == 2'(ch)) && (cw_rw != RW_LATCH); // RQ18
    assign my_latch = cw_write && (cw_sel == 2'(ch)) && (cw_rw == RW_LATCH); // RQ19
    assign rb_hit = cw_write && (cw_sel == SEL_READBACK) && req.data[CW_RB_SEL_BASE + ch];
    assign rb_count = rb_hit && !req.data[CW_RB_COUNT_N];
    assign rb_status = rb_hit && !req.data[CW_RB_STATUS_N];
    assign my_wr = req.wr_pulse && (req.port == 2'(ch)); // RQ17 RQ4
    assign my_rd = req.rd_done && (req.port == 2'(ch)); // RQ17 RQ3

    // Counting element, fed only from the preload register
    pit_count_element u_ce (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .count_clk(count_clk[ch]),
      .gate(gate[ch]),
      .load_req(cst.load_pending),
      .preload({cst.preload_high, cst.preload_low}), // RQ13 RQ14
      .cfg_write(my_cw),
      .count(ce_count),
      .load_ack(ce_ack),
      .out_level(ce_out)
    );

    // Channel storage update
    always_comb
    begin
      next_cst = cst;
      // Transfer finished; a new write in the same cycle sets it again
      if (ce_ack)
      begin
        next_cst.load_pending = 1'b0;
        next_cst.null_count = 1'b0;
      end
      // New control word restarts the byte sequences
      if (my_cw)
      begin
        next_cst.cfg = pit_cfg_t'(req.data[CW_CFG_HI:0]);
        next_cst.wr_phase = BYTE_LSB;
        next_cst.rd_phase = BYTE_LSB;
        next_cst.frozen = 1'b0;
        next_cst.status_held = 1'b0;
        next_cst.load_pending = 1'b0;
        next_cst.null_count = 1'b1;
      end
      // Latch command freezes the snapshot once until read
      if ((my_latch || rb_count) && !cst.frozen)
      begin
        next_cst.frozen = 1'b1; // RQ10
      end
      // Status capture: control bits, output level, null flag
      if (rb_status && !cst.status_held)
      begin
        next_cst.status = {ce_out, cst.null_count, cst.cfg}; // RQ8
        next_cst.status_held = 1'b1;
      end
      // Count bytes follow the programmed format
      if (my_wr)
      begin
        unique case (cst.cfg.rw) // RQ20
          RW_LOW:
          begin
            next_cst.preload_low = req.data; // RQ13
            next_cst.preload_high = BYTE_ZERO; // RQ15
            next_cst.load_pending = 1'b1;
            next_cst.null_count = 1'b1;
          end
          RW_HIGH:
          begin
            next_cst.preload_high = req.data; // RQ13
            next_cst.preload_low = BYTE_ZERO; // RQ15
            next_cst.load_pending = 1'b1;
            next_cst.null_count = 1'b1;
          end
          RW_BOTH:
          begin
            if (cst.wr_phase == BYTE_LSB)
            begin
              next_cst.preload_low = req.data; // RQ13
              next_cst.wr_phase = BYTE_MSB;
            end
            else
            begin
              next_cst.preload_high = req.data; // RQ13
              next_cst.wr_phase = BYTE_LSB;
              next_cst.load_pending = 1'b1;
              next_cst.null_count = 1'b1;
            end
          end
          default:
          begin
            next_cst.load_pending = next_cst.load_pending;
          end
        endcase
      end
      // End of a read: status first, then the snapshot bytes
      if (my_rd)
      begin
        if (cst.status_held)
        begin
          next_cst.status_held = 1'b0;
        end
        else if (cst.cfg.rw == RW_BOTH && cst.rd_phase == BYTE_LSB)
        begin
          next_cst.rd_phase = BYTE_MSB; // RQ11
        end
        else
        begin
          next_cst.rd_phase = BYTE_LSB;
          next_cst.frozen = 1'b0; // RQ10
        end
      end
      // Snapshot follows the counter whenever it is not frozen
      if (!cst.frozen)
      begin
        next_cst.snapshot_latch_low = ce_count[7:0]; // RQ10
        next_cst.snapshot_latch_high = ce_count[15:8];
      end
    end

    // Channel register
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        cst <= '0;
      end
      else
      begin
        cst <= next_cst;
      end
    end

    // Byte offered to the bus: status, else one snapshot half
    always_comb
    begin
      if (cst.status_held)
      begin
        rd_byte[ch] = cst.status; // RQ8
      end
      else if (cst.cfg.rw == RW_HIGH || (cst.cfg.rw == RW_BOTH && cst.rd_phase == BYTE_MSB))
      begin
        rd_byte[ch] = cst.snapshot_latch_high; // RQ11 RQ12
      end
      else
      begin
        rd_byte[ch] = cst.snapshot_latch_low; // RQ11 RQ12
      end
    end

    assign counter_out[ch] = ce_out; // RQ7
  end

  //--------------------------------------------------------------------
  // Data bus buffer
  //--------------------------------------------------------------------
  // Registered read data and enable; idle bus shows zero
  always_comb
  begin
    next_st.oe_n = !rd_drive; // RQ16
    next_st.data_out = BYTE_ZERO;
    if (rd_drive)
    begin
      unique case (port_select)
        2'h0: next_st.data_out = rd_byte[0]; // RQ3 RQ17
        2'h1: next_st.data_out = rd_byte[1];
        2'h2: next_st.data_out = rd_byte[2];
        default: next_st.data_out = BYTE_ZERO; // RQ6
      endcase
    end
  end

  // Buffer register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st.data_out <= BYTE_ZERO;
      st.oe_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign data_out = st.data_out;
  assign data_oe_n = st.oe_n;
endmodule

// ---- sim/pit_bus_interface_assertions.sv ----
//----------------------------------------------------------------------
// Purpose: Port-level checks of the timer bus block
// Assumes: Single clock, reads held three edges by the host
// Notes:   Bound to every instance of the top module
//----------------------------------------------------------------------
`timescale 1ns/1ns
module pit_bus_checker
  import pit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] port_select,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic [2:0] count_clk,
  input wire logic [2:0] gate,
  input wire logic [2:0] counter_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  // No count clock activity for six edges
  sequence quiet_clk;
    (count_clk == 3'h0) [*6];
  endsequence
  a_read_drives: assert property (!cs_n && !rd_n && port_select != PS_CONTROL |=> !data_oe_n)
    else $error("Selected counter read left the bus floating");
  a_oe_cause: assert property (!data_oe_n |-> $past(!cs_n && !rd_n && port_select != PS_CONTROL))
    else $error("Bus driven without a selected read");
  a_idle_zero: assert property (data_oe_n |-> data_out == BYTE_ZERO)
    else $error("Read byte not zero while idle");
  a_write_quiet: assert property (!wr_n && rd_n |=> data_oe_n [*2])
    else $error("Bus driven during a write");
  a_cs_gate: assert property (cs_n |=> data_oe_n)
    else $error("Bus driven while deselected");
  a_ctrl_silent: assert property (!cs_n && !rd_n && port_select == PS_CONTROL |=> data_oe_n)
    else $error("Control port read drove the bus");
  a_rd_release: assert property ($rose(rd_n) |-> ##1 data_oe_n && data_out == BYTE_ZERO)
    else $error("Bus not released after read");
  a_read_stable: assert property (quiet_clk ##0 (!data_oe_n && $past(!data_oe_n)) |-> $stable(data_out))
    else $error("Read byte changed within one read");

  //--------------------------------------------------------------------
  // Coverage
  //--------------------------------------------------------------------
  c_read: cover property (!data_oe_n);
  c_ctrl_write: cover property (!cs_n && !wr_n && port_select == PS_CONTROL);
  c_out_high: cover property ($rose(counter_out[2]));
endmodule

bind pit_bus_interface pit_bus_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n),
  .rd_n(rd_n), .wr_n(wr_n), .port_select(port_select), .data_in(data_in), .data_out(data_out),
  .data_oe_n(data_oe_n), .count_clk(count_clk), .gate(gate), .counter_out(counter_out));

// ---- sim/pit_host_model.sv ----
//----------------------------------------------------------------------
// Purpose: Host processor on the 8-bit peripheral bus
// Assumes: Signals change by non-blocking assignment at an edge, except the blocking idle values set at time zero
// Notes:   Released write data shows the inverse of the last byte
//----------------------------------------------------------------------
`timescale 1ns/1ns
module pit_host_model
  import pit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] port_select,
  output logic [7:0] data_in
);
  // Idle bus at time zero
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select = 2'h0;
    data_in = 8'h00;
  end

  // Write cycle, strobe held low two edges, then a gap of four
  task automatic bus_write(input logic sel_n, input logic [1:0] p, input logic [7:0] d);
    @(posedge sys_clk);
    cs_n <= sel_n;
    wr_n <= 1'b0;
    port_select <= p;
    data_in <= d;
    repeat (2) @(posedge sys_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~d;
    repeat (4) @(posedge sys_clk);
  endtask

  // Read cycle, byte taken at the edge where the strobe is released
  task automatic bus_read(input logic sel_n, input logic [1:0] p, output logic [7:0] d, output logic oe_n);
    @(posedge sys_clk);
    cs_n <= sel_n;
    rd_n <= 1'b0;
    port_select <= p;
    repeat (3) @(posedge sys_clk);
    d = data_out;
    oe_n = data_oe_n;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// ---- sim/pit_bus_interface_tb_top.sv ----
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the timer bus block
// Assumes: Host model drives the bus, bench drives clocks and gates
// Notes:   Each scenario judges its own results
//----------------------------------------------------------------------
`timescale 1ns/1ns
module pit_bus_interface_tb_top;
  import pit_pkg::*;
  logic sys_clk, reset_n, cs_n, rd_n, wr_n, data_oe_n;
  logic [1:0] port_select;
  logic [7:0] data_in, data_out;
  logic [2:0] count_clk, gate, counter_out;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  pit_bus_interface DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select(port_select), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .count_clk(count_clk), .gate(gate), .counter_out(counter_out));
  pit_host_model host (.sys_clk(sys_clk), .data_out(data_out), .data_oe_n(data_oe_n), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_select(port_select), .data_in(data_in));

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] p, input logic [7:0] d);
    host.bus_write(1'b0, p, d);
  endtask

  task automatic rd8(input logic [1:0] p, output logic [15:0] v);
    logic [7:0] b;
    logic oe;
    host.bus_read(1'b0, p, b, oe);
    v = {8'h00, b};
  endtask

  task automatic rd16(input logic [1:0] p, output logic [15:0] v);
    logic [15:0] lo, hi;
    rd8(p, lo);
    rd8(p, hi);
    v = {hi[7:0], lo[7:0]};
  endtask

  // Count clock pulses, five system cycles each
  task automatic tick(input int k, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      count_clk[k] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      count_clk[k] <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  task automatic t_load();
    logic [15:0] v;
    logic [15:0] vals [3] = '{16'h1234, 16'hA55A, 16'h0F0E};
    chk({15'h0000, data_oe_n}, 16'h0001);
    for (int k = 0; k < 3; k++)
    begin
      wr(2'h3, {k[1:0], RW_BOTH, 4'h4});
      wr(k[1:0], vals[k][7:0]);
      wr(k[1:0], vals[k][15:8]);
    end
    rd16(2'h0, v);
    chk(v, COUNT_ZERO);
    for (int k = 0; k < 3; k++)
      tick(k, 1);
    for (int k = 0; k < 3; k++)
    begin
      rd16(k[1:0], v);
      chk(v, vals[k]);
    end
  endtask

  task automatic t_latch();
    logic [15:0] v;
    wr(2'h3, 8'h00);
    @(posedge sys_clk);
    gate[0] <= 1'b1;
    tick(0, 2);
    gate[0] <= 1'b0;
    rd16(2'h0, v);
    chk(v, 16'h1234);
    rd16(2'h0, v);
    chk(v, 16'h1232);
    wr(2'h3, 8'hE2);
    rd8(2'h0, v);
    chk(v, {8'h00, 2'h0, RW_BOTH, 4'h4});
    // Read-back latching count and status, then let the counter move on
    wr(2'h3, 8'hC2);
    gate[0] <= 1'b1;
    tick(0, 1);
    gate[0] <= 1'b0;
    rd8(2'h0, v);
    chk(v, {8'h00, 2'h0, RW_BOTH, 4'h4});
    rd16(2'h0, v);
    chk(v, 16'h1232);
  endtask

  task automatic t_single();
    logic [15:0] v;
    wr(2'h3, {2'h1, RW_HIGH, 4'h0});
    wr(2'h1, 8'h5A);
    tick(1, 1);
    gate[1] <= 1'b1;
    tick(1, 1);
    gate[1] <= 1'b0;
    rd8(2'h1, v);
    chk(v, 16'h0059);
    wr(2'h3, {2'h2, RW_LOW, 4'h0});
    wr(2'h2, 8'h03);
    tick(2, 1);
    gate[2] <= 1'b1;
    tick(2, 2);
    chk({13'h0000, counter_out}, 16'h0000);
    tick(2, 1);
    chk({13'h0000, counter_out}, 16'h0004);
    gate[2] <= 1'b0;
  endtask

  task automatic t_refuse();
    logic [15:0] v;
    logic [7:0] b;
    logic oe;
    host.bus_write(1'b1, 2'h3, 8'h50);
    host.bus_write(1'b1, 2'h1, 8'hFF);
    tick(1, 1);
    host.bus_read(1'b1, 2'h1, b, oe);
    chk({15'h0000, oe}, 16'h0001);
    rd8(2'h1, v);
    chk(v, 16'h0059);
    host.bus_read(1'b0, 2'h3, b, oe);
    chk({15'h0000, oe}, 16'h0001);
    rd8(2'h1, v);
    chk(v, 16'h0059);
  endtask

  //--------------------------------------------------------------------
  // Clock, watchdog and main sequence
  //--------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cuts a hang short
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  // Reset, then every scenario in turn
  initial
  begin
    reset_n = 1'b0;
    count_clk = 3'h0;
    gate = 3'h0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_load();
    t_latch();
    t_single();
    t_refuse();
    print_verdict();
  end
endmodule
